// *** core/sso_override_ctl.sv ***
// state override control register with forced shutdown sequencing
// Summary of operation
// [RL1] override register at 0x28, protected writes refused
// [RL2] power-on contents come from nonvolatile memory
// [RL3] interrupt forced low when bit 3 set
// [RL4] hold-active flag makes sleep input ignored
// [RL5] hardware sets hold flag entering sequence 1
// [RL6] bus clears hold flag, writing one ignored
// [RL7] no button: 00 normal, 01 powerdown then resume
// [RL8] no button: 10 powerdown, resume after 1s
// [RL9] no button: 11 resume on activity low/alarm
// [RL10] button: 00 normal, 01 powerdown then sequence 1
// [RL11] button: 10 sequence 1 after 1s or press
// [RL12] button: 11 sequence 1 on alarm or press
// [RL13] rtc wake enable sets hold flag on alarm
// [RL14] nonzero code write starts action, mode latched
`timescale 1ns/10ps
module sso_override_ctl
  import sso_pkg::*;
#(
  parameter int RESUME_CNT = RESUME_CYCLES
) (
  input  wire logic         CLK_SYS_I,
  input  wire logic         RST_I,
  input  wire sso_bus_req_t BUS_REQ_I,
  input  wire logic         CTL_PROTECT_I,
  input  wire logic         NVM_LOAD_I,
  input  wire logic [7:0]   NVM_DATA_I,
  input  wire logic         FAULT_PENDING_I,
  input  wire logic         SLEEP_I,
  input  wire logic         ACTIVITY_PIN_I,
  input  wire logic         POWER_BUTTON_N_I,
  input  wire logic         BUTTON_FUNCTION_ENABLE_I,
  input  wire logic         RTC_ALARM_I,
  input  wire logic         RTC_WAKE_EN_I,
  input  wire logic         SEQ1_ENTRY_I,
  input  wire logic         POWERDOWN_DONE_I,
  output logic [7:0]        RDATA_O,
  output logic              INTERRUPT_OUT_N_O,
  output logic              SLEEP_REQ_O,
  output sso_seq_ctl_t      SEQ_CTL_O
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_PDOWN = 5'h02,
    ST_WAIT  = 5'h04,
    ST_EVENT = 5'h08,
    ST_DONE  = 5'h10
  } sso_state_t;

  function automatic logic ovr_write(input sso_bus_req_t r, input logic prot);
    ovr_write = r.wr && (r.addr == OVR_OFFSET) && !prot;
  endfunction

  logic [1:0]  shdn_q;
  logic        int_force_q;
  logic        hold_q;
  logic        btn_mode_q;
  sso_state_t  state_q;
  sso_state_t  state_d;
  logic [31:0] cnt_q;
  logic        wr_ok;
  logic        start;
  logic        timer_done;
  logic        resume;

  assign wr_ok      = ovr_write(BUS_REQ_I, CTL_PROTECT_I); // RL1
  assign start      = wr_ok && (BUS_REQ_I.wdata[SHDN_LSB +: 2] != SHDN_NORMAL); // RL14
  assign timer_done = (cnt_q >= 32'(RESUME_CNT - 1));

  // field bits 3 and 1:0
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      int_force_q <= 1'b0;
      shdn_q      <= SHDN_NORMAL;
    end else if (NVM_LOAD_I) begin
      int_force_q <= NVM_DATA_I[INT_FORCE_BIT]; // RL2
      shdn_q      <= NVM_DATA_I[SHDN_LSB +: 2]; // RL2
    end else if (wr_ok) begin
      int_force_q <= BUS_REQ_I.wdata[INT_FORCE_BIT]; // RL1
      shdn_q      <= BUS_REQ_I.wdata[SHDN_LSB +: 2];
    end else if (state_q == ST_DONE) begin
      shdn_q      <= SHDN_NORMAL;
    end
  end

  // hold flag: hardware set beats a bus clear in the same cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      hold_q <= 1'b0;
    end else if (SEQ1_ENTRY_I || (RTC_WAKE_EN_I && RTC_ALARM_I)) begin
      hold_q <= 1'b1; // RL5 RL13
    end else if (NVM_LOAD_I) begin
      hold_q <= NVM_DATA_I[HOLD_BIT]; // RL2
    end else if (wr_ok && !BUS_REQ_I.wdata[HOLD_BIT]) begin
      hold_q <= 1'b0; // RL6
    end
  end

  // interpretation fixed at the write so a later enable change cannot confuse it
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      btn_mode_q <= 1'b0;
    end else if (start && state_q == ST_IDLE) begin
      btn_mode_q <= BUTTON_FUNCTION_ENABLE_I; // RL14
    end
  end

  always_comb begin
    case (shdn_q)
      SHDN_NOW:   resume = 1'b1; // RL7 RL10
      SHDN_DELAY: resume = timer_done || (btn_mode_q && !POWER_BUTTON_N_I); // RL8 RL11
      SHDN_EVENT: resume = btn_mode_q ? (RTC_ALARM_I || !POWER_BUTTON_N_I) // RL12
                                      : (!ACTIVITY_PIN_I || RTC_ALARM_I); // RL9
      default:    resume = 1'b1;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (start) state_d = ST_PDOWN;
      ST_PDOWN: begin
        if (POWERDOWN_DONE_I) begin
          state_d = (shdn_q == SHDN_DELAY) ? ST_WAIT : ST_EVENT;
        end
      end
      ST_WAIT:  if (resume) state_d = ST_DONE;
      ST_EVENT: if (resume) state_d = ST_DONE;
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // one-second timer counts only while waiting
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || state_q != ST_WAIT) begin
      cnt_q <= 32'h0;
    end else if (!timer_done) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (BUS_REQ_I.rd && BUS_REQ_I.addr == OVR_OFFSET) begin
      RDATA_O <= {4'h0, int_force_q, hold_q, shdn_q};
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      INTERRUPT_OUT_N_O <= 1'b1;
      SLEEP_REQ_O       <= 1'b0;
      SEQ_CTL_O         <= '0;
    end else begin
      INTERRUPT_OUT_N_O       <= !(int_force_q || FAULT_PENDING_I); // RL3
      SLEEP_REQ_O             <= !hold_q && SLEEP_I; // RL4
      SEQ_CTL_O.req_powerdown <= (state_q == ST_PDOWN);
      SEQ_CTL_O.req_seq1      <= (state_q == ST_DONE) && btn_mode_q; // RL10
      SEQ_CTL_O.act_control   <= (state_q == ST_IDLE) && !btn_mode_q;
    end
  end

endmodule

// *** core/sso_pkg.sv ***
// package: register map, field layout and timing for the state override control block
package sso_pkg;
  localparam logic [7:0] OVR_OFFSET      = 8'h28;
  localparam int         INT_FORCE_BIT   = 3;
  localparam int         HOLD_BIT        = 2;
  localparam int         SHDN_LSB        = 0;
  localparam logic [7:0] OVR_WRITE_MASK  = 8'h0F;
  localparam logic [1:0] SHDN_NORMAL     = 2'h0;
  localparam logic [1:0] SHDN_NOW        = 2'h1;
  localparam logic [1:0] SHDN_DELAY      = 2'h2;
  localparam logic [1:0] SHDN_EVENT      = 2'h3;
  localparam int         CLK_HZ          = 200000000;
  localparam int         RESUME_DELAY_S  = 1;
  localparam int         RESUME_CYCLES   = RESUME_DELAY_S * CLK_HZ;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sso_bus_req_t;

  typedef struct packed {
    logic       req_powerdown;
    logic       req_seq1;
    logic       act_control;
  } sso_seq_ctl_t;
endpackage

// *** tb/sso_override_ctl_assertions.sv ***
// checker of the state override control block
`timescale 1ns/10ps
module sso_override_ctl_assertions
  import sso_pkg::*;
(
  input wire logic         CLK_SYS_I,
  input wire logic         RST_I,
  input wire sso_bus_req_t BUS_REQ_I,
  input wire logic         CTL_PROTECT_I,
  input wire logic         NVM_LOAD_I,
  input wire logic         SLEEP_I,
  input wire logic         SEQ1_ENTRY_I,
  input wire logic [7:0]   RDATA_O,
  input wire logic         INTERRUPT_OUT_N_O,
  input wire logic         SLEEP_REQ_O,
  input wire sso_seq_ctl_t SEQ_CTL_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  // nvm load outranks the bus, so it must be absent
  sequence s_force_wr;
    BUS_REQ_I.wr && BUS_REQ_I.addr == OVR_OFFSET && !CTL_PROTECT_I
      && BUS_REQ_I.wdata[3] && !NVM_LOAD_I;
  endsequence
  AST_RD_HI: assert property (BUS_REQ_I.rd |=> RDATA_O[7:4] == 4'h0)
    else $error("rdata upper set");
  AST_RD_UNMAP: assert property (
    BUS_REQ_I.rd && BUS_REQ_I.addr != OVR_OFFSET |=> RDATA_O == 8'h00) else $error("unmapped");
  AST_INT_FORCE: assert property (s_force_wr |-> ##2 !INTERRUPT_OUT_N_O)
    else $error("irq not forced");
  AST_SLEEP_OFF: assert property (!SLEEP_I |=> !SLEEP_REQ_O)
    else $error("sleep without input");
  AST_SEQ1_HOLD: assert property (SEQ1_ENTRY_I |-> ##2 !SLEEP_REQ_O)
    else $error("hold not set");
  AST_PD_EXCL: assert property (SEQ_CTL_O.req_powerdown |-> !SEQ_CTL_O.act_control)
    else $error("act during powerdown");
  AST_SEQ1_PULSE: assert property ($rose(SEQ_CTL_O.req_seq1) |=> !SEQ_CTL_O.req_seq1)
    else $error("seq1 not a pulse");
  AST_RST_OUT: assert property ($fell(RST_I) |-> SEQ_CTL_O == '0 && RDATA_O == 8'h00)
    else $error("outputs after reset");
endmodule
bind sso_override_ctl sso_override_ctl_assertions u_ast (.*);

// *** tb/test_sso_override_ctl.sv ***
// self-checking bench of the state override control block
`timescale 1ns/10ps
module test_sso_override_ctl;
  import sso_pkg::*;
  logic c = 0, r = 1, p = 0, nl = 0, f = 0, sl = 0, be = 0, al = 0, s1 = 0, dn = 0, irq, srq;
  logic [7:0]   rdo;
  logic [3:0]   m = 4'h0;
  logic [31:0]  s = 85;
  int           num_errors = 0, checks = 0, seq1_n = 0, seq1_e = 0;
  sso_bus_req_t q = '0;
  sso_seq_ctl_t sc;
  sso_override_ctl #(.RESUME_CNT(20)) dut_u (.CLK_SYS_I(c), .RST_I(r), .BUS_REQ_I(q),
    .CTL_PROTECT_I(p), .NVM_LOAD_I(nl), .NVM_DATA_I(8'h0C), .FAULT_PENDING_I(f),
    .SLEEP_I(sl), .ACTIVITY_PIN_I(1'b0), .POWER_BUTTON_N_I(1'b1), .RTC_ALARM_I(al),
    .BUTTON_FUNCTION_ENABLE_I(be), .RTC_WAKE_EN_I(1'b0), .SEQ1_ENTRY_I(s1),
    .POWERDOWN_DONE_I(dn), .RDATA_O(rdo), .INTERRUPT_OUT_N_O(irq), .SLEEP_REQ_O(srq),
    .SEQ_CTL_O(sc));
  initial forever #2.5 c = ~c;
  // count sequence 1 requests so none is missed between checks
  always @(posedge c) if (sc.req_seq1 === 1'b1) seq1_n++;
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // one idle cycle after each access so q is never assigned twice at one edge
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    q = '{w, !w, a, d};
    @(negedge c) q = '0;
    if (w && a == OVR_OFFSET && !p) m = {d[3], m[2] & d[2], d[1:0]};
    if (!w) chk("rdata", (a == OVR_OFFSET) ? {4'h0, m} : 8'h00, rdo);
    @(negedge c);
  endtask
  task automatic ok;
    repeat (2) @(negedge c);
    chk("irq_sleep", {6'h0, !(m[3] | f), sl & !m[2]}, {6'h0, irq, srq});
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(negedge c);
    r = 0;
    nl = 1;
    @(negedge c) nl = 0;
    m = 4'hC;
    acc(0, OVR_OFFSET, 0);
    sl = 1;
    f = 1;
    ok;
    acc(1, OVR_OFFSET, 0);
    ok;
    s1 = 1;
    @(negedge c) s1 = 0;
    m[2] = 1;
    ok;
    repeat (12) begin
      s = xs(s);
      p = s[0];
      f = s[1];
      acc(1, s[2] ? OVR_OFFSET : s[15:8], s[23:16] & 8'hFC);
      acc(0, s[3] ? OVR_OFFSET : s[31:24], 0);
      ok;
    end
    p = 0;
    for (int k = 1; k < 4; k++) begin
      be = k[1];
      acc(1, OVR_OFFSET, 8'(k));
      chk("pdown", 8'h01, {7'h0, sc.req_powerdown});
      dn = 1;
      al = k[0] & k[1];
      @(negedge c) dn = 0;
      repeat (24) @(negedge c);
      al = 0;
      m[1:0] = 2'h0;
      acc(0, OVR_OFFSET, 0);
      seq1_e += be;
      chk("seq1", 8'(seq1_e), 8'(seq1_n));
      chk("act", {7'h0, !be}, {7'h0, sc.act_control});
    end
    end_of_test;
  end
endmodule
